/* File: bench/hspio_board.sv */
/*
 * Board model: resolves pin levels and feeds the threshold comparators.
 * Assumes external sources drive every released pin.
 */
`timescale 1ns/1ps

module hspio_board (
    input  wire logic [3:0] pg_out,
    input  wire logic [3:0] pg_oe_b,
    input  wire logic [3:0] adc_out,
    input  wire logic [3:0] adc_oe_b,
    input  wire logic [3:0] pg_ext,
    input  wire logic [3:0] adc_ext,
    output logic      [3:0] pg_level,
    output logic      [3:0] adc_level
);
    // Released pins show the external source, driven ones the device
    assign pg_level  = (pg_out & ~pg_oe_b) | (pg_ext & pg_oe_b);
    assign adc_level = (adc_out & ~adc_oe_b) | (adc_ext & adc_oe_b);
endmodule

/* File: bench/hspio_top_properties.sv */
/*
 * Port-level properties of the hot swap pin configuration block.
 * Assumes it is bound into hspio_top and sees only its ports.
 */
`timescale 1ns/1ps

module hspio_top_properties (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] power_good_pin_out,
    input wire logic [3:0] power_good_pin_oe_b,
    input wire logic [3:0] adc_io_pin_out,
    input wire logic [3:0] adc_io_pin_oe_b,
    input wire logic [3:0] adc_channel_enable,
    input wire logic       power_good_latched,
    input wire logic       overcurrent_live_flag,
    input wire logic       current_limit_indicator_enable,
    input wire logic       load_power_foldback_enable,
    input wire logic [3:0] sense_voltage_step,
    input wire logic [7:0] output_voltage_level,
    input wire logic [4:0] sense_voltage_mv,
    input wire logic [7:0] current_limit_scale
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_wr(x);
        (reg_wr_en && reg_addr == x) ##1 !(reg_wr_en && reg_addr == x);
    endsequence

    property p_sense; 1'b1 |=> sense_voltage_mv == 5'h0F + $past(sense_voltage_step); endproperty
    property p_fb_off; !load_power_foldback_enable |=> current_limit_scale == 8'hFF; endproperty
    property p_fb_on;
        load_power_foldback_enable |=> current_limit_scale == 8'hFF - ($past(output_voltage_level) >> 1);
    endproperty
    property p_chan; s_wr(8'h11) |=> adc_channel_enable == 4'($past(reg_wdata, 2)); endproperty
    property p_dir;
        s_wr(8'h12) |=> adc_io_pin_oe_b == ~4'($past(reg_wdata, 2) >> 4)
            && ((adc_io_pin_out ^ 4'($past(reg_wdata, 2))) & ~adc_io_pin_oe_b) == 4'h0;
    endproperty
    property p_ind_start;
        current_limit_indicator_enable && !power_good_latched |=> !power_good_pin_oe_b[1] && !power_good_pin_out[1];
    endproperty
    property p_ind_oc;
        current_limit_indicator_enable && power_good_latched && overcurrent_live_flag
            |=> !power_good_pin_oe_b[1] && !power_good_pin_out[1];
    endproperty
    property p_ind_rel;
        current_limit_indicator_enable && power_good_latched && !overcurrent_live_flag |=> power_good_pin_oe_b[1];
    endproperty
    property p_unmapped;
        reg_rd_en && !(reg_addr inside {8'h02, 8'h10, 8'h11, 8'h12}) |=> reg_rdata == 8'h00;
    endproperty
    property p_rd_hold; !reg_rd_en |=> $stable(reg_rdata); endproperty

    a_sense: assert property (p_sense) else $error("sense voltage wrong");
    a_fb_off: assert property (p_fb_off) else $error("scale not full");
    a_fb_on: assert property (p_fb_on) else $error("foldback scale wrong");
    a_chan: assert property (p_chan) else $error("channel select wrong");
    a_dir: assert property (p_dir) else $error("adc pin drive wrong");
    a_ind_start: assert property (p_ind_start) else $error("pin two not low in startup");
    a_ind_oc: assert property (p_ind_oc) else $error("pin two not low in limit");
    a_ind_rel: assert property (p_ind_rel) else $error("pin two not released");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed");

    c_oc: cover property (current_limit_indicator_enable && power_good_latched && overcurrent_live_flag);
    c_fb: cover property (load_power_foldback_enable);
    c_status: cover property (reg_rd_en && reg_addr == 8'h02);
endmodule

bind hspio_top hspio_top_properties hspio_top_properties_i (.clk, .rst_b, .reg_addr, .reg_wr_en, .reg_wdata,
    .reg_rd_en, .reg_rdata, .power_good_pin_out, .power_good_pin_oe_b, .adc_io_pin_out, .adc_io_pin_oe_b,
    .adc_channel_enable, .power_good_latched, .overcurrent_live_flag, .current_limit_indicator_enable,
    .load_power_foldback_enable, .sense_voltage_step, .output_voltage_level, .sense_voltage_mv,
    .current_limit_scale);

/* File: bench/testbench.sv */
/*
 * Self-checking bench of the pin configuration block with a reference model.
 * Assumes hspio_top, hspio_board and the bound properties are compiled first.
 */
`timescale 1ns/1ps

module testbench;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, vlev = 8'h00, rdata, rv, scale;
    logic        wr_en = 1'b0, rd_en = 1'b0, lat = 1'b0, oc = 1'b0, ind = 1'b0, fb = 1'b0, pia, efa;
    logic [3:0]  pg_out, pg_oe_b, pg_lv, adc_out, adc_oe_b, adc_lv, chan, ep, ea;
    logic [3:0]  step = 4'h0, pge = 4'h0, adce = 4'h0;
    logic [1:0]  seq = 2'b00;
    logic [4:0]  mv;
    logic [31:0] s = 32'h0000_0032, a, b;
    int          cfg[3];
    int          miscompares = 0;
    int          tests_run = 0;

    always #2 clk = ~clk;

    hspio_top hspio_top_i (.clk, .rst_b, .reg_addr(addr), .reg_wr_en(wr_en), .reg_wdata(wdata),
        .reg_rd_en(rd_en), .reg_rdata(rdata), .power_good_pin_in(pg_lv), .power_good_pin_out(pg_out),
        .power_good_pin_oe_b(pg_oe_b), .power_good_pin_above_threshold(pg_lv), .adc_io_pin_out(adc_out),
        .adc_io_pin_oe_b(adc_oe_b), .adc_io_pin_above_threshold(adc_lv), .adc_channel_enable(chan),
        .power_good_sequence(seq), .power_good_latched(lat), .overcurrent_live_flag(oc),
        .power_good_input_active(pia), .external_fault_active(efa), .current_limit_indicator_enable(ind),
        .load_power_foldback_enable(fb), .sense_voltage_step(step), .output_voltage_level(vlev),
        .sense_voltage_mv(mv), .current_limit_scale(scale));

    hspio_board hspio_board_i (.pg_out, .pg_oe_b, .adc_out, .adc_oe_b, .pg_ext(pge), .adc_ext(adce),
        .pg_level(pg_lv), .adc_level(adc_lv));

    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        if (ad >= 8'h10 && ad <= 8'h12)
            cfg[ad - 8'h10] = d;
    endtask

    task rd(input logic [7:0] ad);
        @(posedge clk);
        addr <= ad;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        rv = rdata;
    endtask

    task check_pins;
        logic [3:0] eo;
        logic [3:0] ao;
        logic [1:0] m;
        eo = 4'hF;
        ep = pge;
        for (int i = 0; i < 4; i++) begin
            m = 2'(cfg[0] >> (2 * i));
            if (m == 2'b01) begin
                eo[i] = 1'b0;
                ep[i] = cfg[1][4 + i];
            end else if (m[1] && i < 2) begin
                eo[i] = 1'b0;
                ep[i] = seq[i] ^ m[0];
            end
        end
        if (ind) begin
            eo[1] = lat & ~oc;
            ep[1] = eo[1] & pge[1];
        end
        ao = ~cfg[2][7:4];
        ea = (cfg[2][3:0] & ~ao) | (adce & ao);
        chk("pg_oe_b", pg_oe_b, eo);
        chk("pg_level", pg_lv, ep);
        chk("adc_oe_b", adc_oe_b, ao);
        chk("adc_level", adc_lv, ea);
        chk("adc_channel", chan, cfg[1][3:0]);
        chk("pg_input", pia, cfg[0][5] & (ep[2] ^ cfg[0][4]));
        chk("ext_fault", efa, cfg[0][7] & (ep[3] ^ cfg[0][6]));
        chk("sense_mv", mv, 8'h0F + step);
        chk("scale", scale, fb ? 8'hFF - (vlev >> 1) : 8'hFF);
    endtask

    task final_report;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        // About 26 cycles per pass; more than twice that is allowed
        repeat (20 + 60 * 64) @(posedge clk);
        miscompares++;
        final_report;
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int r = 0; r < 3; r++) begin
            rd(8'h10 + 8'(r));
            chk("reset cfg", rv, 8'h00);
        end
        chk("reset oe_b", {pg_oe_b, adc_oe_b}, 8'hFF);
        repeat (60) begin
            a = rnd();
            b = rnd();
            wr(8'h10, a[7:0]);
            wr(8'h11, a[15:8]);
            wr(8'h12, a[23:16]);
            wr(8'h02, a[31:24]);
            @(posedge clk);
            pge <= b[3:0];
            adce <= b[7:4];
            seq <= b[9:8];
            lat <= b[10];
            oc <= b[11];
            ind <= b[12];
            fb <= b[13];
            step <= b[17:14];
            vlev <= b[25:18];
            repeat (4) @(posedge clk);
            @(negedge clk);
            check_pins;
            for (int r = 0; r < 3; r++) begin
                rd(8'h10 + 8'(r));
                chk("cfg readback", rv, cfg[r][7:0]);
            end
            rd(8'h02);
            chk("status", rv, {ep, ea});
            rd(8'h02);
            chk("status again", rv, {ep, ea});
            rd(a[31:24] | 8'h20);
            chk("unmapped", rv, 8'h00);
        end
        // Reset again mid-run; inputs go quiet so history-based properties see zeros
        @(posedge clk);
        rst_b <= 1'b0;
        {seq, lat, oc, ind, fb, step, vlev} <= '0;
        @(negedge clk);
        chk("reset pins", {pg_oe_b, adc_oe_b, chan, pia, efa}, {8'hFF, 4'h0, 2'h0});
        chk("reset values", {mv, scale, rdata}, {5'h0F, 8'hFF, 8'h00});
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int r = 0; r < 3; r++) begin
            rd(8'h10 + 8'(r));
            chk("reset cfg again", rv, 8'h00);
        end
        final_report;
    end
endmodule

/* File: hdl/hspio_cfg_if.sv */
/*
 * Configuration and status carrier between the register file and the pin core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface hspio_cfg_if;
    hspio_pkg::hspio_byte_t pg_config_a;
    hspio_pkg::hspio_byte_t pg_config_b;
    hspio_pkg::hspio_byte_t adc_io_config;
    hspio_pkg::hspio_byte_t input_status;

    modport regs (
        output pg_config_a,
        output pg_config_b,
        output adc_io_config,
        input  input_status
    );

    modport core (
        input  pg_config_a,
        input  pg_config_b,
        input  adc_io_config,
        output input_status
    );
endinterface

/* File: hdl/hspio_consts.svh */
/*
 * Register offsets, field positions, reset values and fixed figures of the
 * hot swap pin configuration block.
 * Assumes it is included by bare name by the design files.
 */
`ifndef HSPIO_CONSTS_SVH
`define HSPIO_CONSTS_SVH

// Register offsets
`define HSPIO_ADDR_INPUT_STATUS   8'h02
`define HSPIO_ADDR_PG_CONFIG_A    8'h10
`define HSPIO_ADDR_PG_CONFIG_B    8'h11
`define HSPIO_ADDR_ADC_IO_CONFIG  8'h12

// Reset values
`define HSPIO_RST_PG_CONFIG_A     8'h00
`define HSPIO_RST_PG_CONFIG_B     8'h00
`define HSPIO_RST_ADC_IO_CONFIG   8'h00
`define HSPIO_RDATA_UNMAPPED      8'h00

// Field positions
`define HSPIO_PG_MODE_WIDTH       2
`define HSPIO_PG_DATA_LSB         4
`define HSPIO_ADC_MON_LSB         0
`define HSPIO_ADC_DIR_LSB         4
`define HSPIO_ADC_DATA_LSB        0
`define HSPIO_STATUS_PG_LSB       4
`define HSPIO_STATUS_ADC_LSB      0

// Pin counts
`define HSPIO_PG_PINS             4
`define HSPIO_ADC_PINS            4

// Sense voltage range, millivolts, 1 mV per step
`define HSPIO_SENSE_MIN_MV        5'h0F
`define HSPIO_SENSE_MAX_MV        5'h1E

// Full scale of the foldback limit scale
`define HSPIO_LIMIT_FULL          8'hFF

`endif

/* File: hdl/hspio_pkg.sv */
/*
 * Types of the hot swap pin configuration block.
 * Assumes hspio_consts.svh is reachable on the include path.
 */
package hspio_pkg;

    // Per-pin mode of a power-good pin
    typedef enum logic [1:0] {
        HSPIO_MODE_GP_IN    = 2'b00,
        HSPIO_MODE_GP_OUT   = 2'b01,
        HSPIO_MODE_SPEC     = 2'b10,
        HSPIO_MODE_SPEC_INV = 2'b11
    } hspio_mode_e;

    typedef logic [7:0] hspio_byte_t;

endpackage

/* File: hdl/hspio_regs.sv */
/*
 * Register file of the pin configuration block: three read/write
 * configuration registers and the read-only input level status.
 * Assumes a synchronous single-cycle register port on clk.
 */
`timescale 1ns/1ps
`include "hspio_consts.svh"

module hspio_regs (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [7:0]   reg_addr,
    input  wire logic         reg_wr_en,
    input  wire logic [7:0]   reg_wdata,
    input  wire logic         reg_rd_en,
    output logic      [7:0]   reg_rdata,
    hspio_cfg_if.regs         cfg
);

    hspio_pkg::hspio_byte_t pg_config_a;
    hspio_pkg::hspio_byte_t pg_config_b;
    hspio_pkg::hspio_byte_t adc_io_config;
    hspio_pkg::hspio_byte_t rdata;
    hspio_pkg::hspio_byte_t next_pg_config_a;
    hspio_pkg::hspio_byte_t next_pg_config_b;
    hspio_pkg::hspio_byte_t next_adc_io_config;
    hspio_pkg::hspio_byte_t next_rdata;

    always_comb begin
        next_pg_config_a   = pg_config_a;
        next_pg_config_b   = pg_config_b;
        next_adc_io_config = adc_io_config;
        next_rdata         = rdata;
        if (reg_wr_en) begin
            unique case (reg_addr)
                `HSPIO_ADDR_PG_CONFIG_A:   next_pg_config_a   = reg_wdata; // RQ1
                `HSPIO_ADDR_PG_CONFIG_B:   next_pg_config_b   = reg_wdata; // RQ5
                `HSPIO_ADDR_ADC_IO_CONFIG: next_adc_io_config = reg_wdata; // RQ1
                default: ;
            endcase
        end
        if (reg_rd_en) begin
            unique case (reg_addr)
                `HSPIO_ADDR_INPUT_STATUS:  next_rdata = cfg.input_status; // RQ13
                `HSPIO_ADDR_PG_CONFIG_A:   next_rdata = pg_config_a;
                `HSPIO_ADDR_PG_CONFIG_B:   next_rdata = pg_config_b;
                `HSPIO_ADDR_ADC_IO_CONFIG: next_rdata = adc_io_config;
                default:                   next_rdata = `HSPIO_RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pg_config_a   <= `HSPIO_RST_PG_CONFIG_A;
            pg_config_b   <= `HSPIO_RST_PG_CONFIG_B;
            adc_io_config <= `HSPIO_RST_ADC_IO_CONFIG;
            rdata         <= `HSPIO_RDATA_UNMAPPED;
        end else begin
            pg_config_a   <= next_pg_config_a;
            pg_config_b   <= next_pg_config_b;
            adc_io_config <= next_adc_io_config;
            rdata         <= next_rdata;
        end
    end

    assign reg_rdata         = rdata;
    assign cfg.pg_config_a   = pg_config_a;
    assign cfg.pg_config_b   = pg_config_b;
    assign cfg.adc_io_config = adc_io_config;

endmodule

/* File: hdl/hspio_top.sv */
/*
 * Top of the hot swap pin configuration block: power-good and ADC pins,
 * their special roles, input level capture and current-limit settings.
 * Assumes comparator results and sequencer signals are synchronous to clk.
 */
// Function
// [RQ1] Configure all eight pins as GPIO
// [RQ2] Pins one, two: sequential power-good outputs, polarity
// [RQ3] Pin three: power-good input, selectable polarity
// [RQ4] Pin four: external fault input, selectable polarity
// [RQ5] Output data from upper and lower nibbles
// [RQ6] Selected ADC pins routed to converter channels
// [RQ7] Indicator mode: pin two low during startup
// [RQ8] Indicator mode: released when no overcurrent
// [RQ9] Indicator mode: pulled low during current limit
// [RQ10] All pins compared, results in status register
// [RQ11] Sense voltage 15..30 mV in 1 mV steps
// [RQ12] Foldback reduces limit as output voltage rises
// [RQ13] Status read-only, reads never clear it

`timescale 1ns/1ps
`include "hspio_consts.svh"

module hspio_top (
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Register port
    input  wire logic [7:0]   reg_addr,
    input  wire logic         reg_wr_en,
    input  wire logic [7:0]   reg_wdata,
    input  wire logic         reg_rd_en,
    output logic      [7:0]   reg_rdata,
    // Power-good pins, index 0 is pin one
    input  wire logic [3:0]   power_good_pin_in,
    output logic      [3:0]   power_good_pin_out,
    output logic      [3:0]   power_good_pin_oe_b,
    input  wire logic [3:0]   power_good_pin_above_threshold,
    // ADC pins, index 0 is pin one
    output logic      [3:0]   adc_io_pin_out,
    output logic      [3:0]   adc_io_pin_oe_b,
    input  wire logic [3:0]   adc_io_pin_above_threshold,
    output logic      [3:0]   adc_channel_enable,
    // Sequencer and fault state
    input  wire logic [1:0]   power_good_sequence,
    input  wire logic         power_good_latched,
    input  wire logic         overcurrent_live_flag,
    output logic              power_good_input_active,
    output logic              external_fault_active,
    // Current-limit settings
    input  wire logic         current_limit_indicator_enable,
    input  wire logic         load_power_foldback_enable,
    input  wire logic [3:0]   sense_voltage_step,
    input  wire logic [7:0]   output_voltage_level,
    output logic      [4:0]   sense_voltage_mv,
    output logic      [7:0]   current_limit_scale
);

    hspio_cfg_if cfg_bus ();

    hspio_regs u_regs (
        .clk       (clk),
        .rst_b     (rst_b),
        .reg_addr  (reg_addr),
        .reg_wr_en (reg_wr_en),
        .reg_wdata (reg_wdata),
        .reg_rd_en (reg_rd_en),
        .reg_rdata (reg_rdata),
        .cfg       (cfg_bus.regs)
    );

    // Registered state
    logic [7:0] input_status;
    logic [3:0] pg_out;
    logic [3:0] pg_oe_b;
    logic [3:0] adc_out;
    logic [3:0] adc_oe_b;
    logic [3:0] adc_chan;
    logic       pg_in_active;
    logic       ext_fault;
    logic [4:0] sense_mv;
    logic [7:0] limit_scale;

    // Next values
    logic [7:0] next_input_status;
    logic [3:0] next_pg_out;
    logic [3:0] next_pg_oe_b;
    logic [3:0] next_adc_out;
    logic [3:0] next_adc_oe_b;
    logic [3:0] next_adc_chan;
    logic       next_pg_in_active;
    logic       next_ext_fault;
    logic [4:0] next_sense_mv;
    logic [7:0] next_limit_scale;

    // Per-pin mode and role decode
    hspio_pkg::hspio_mode_e pg_mode [4];
    logic [3:0]             pg_is_special;
    logic [3:0]             pg_invert;

    genvar gi;
    generate
        for (gi = 0; gi < `HSPIO_PG_PINS; gi++) begin : g_pin
            logic gp_drive;
            logic seq_level;

            assign pg_mode[gi] = hspio_pkg::hspio_mode_e'(
                cfg_bus.pg_config_a[gi*`HSPIO_PG_MODE_WIDTH +: `HSPIO_PG_MODE_WIDTH]); // RQ1
            assign pg_is_special[gi] = (pg_mode[gi] == hspio_pkg::HSPIO_MODE_SPEC) ||
                                       (pg_mode[gi] == hspio_pkg::HSPIO_MODE_SPEC_INV);
            assign pg_invert[gi]     = (pg_mode[gi] == hspio_pkg::HSPIO_MODE_SPEC_INV);
            assign gp_drive          = (pg_mode[gi] == hspio_pkg::HSPIO_MODE_GP_OUT);

            // Pins one and two carry a sequencer output in their special role
            if (gi < 2) begin : g_seq
                assign seq_level = power_good_sequence[gi] ^ pg_invert[gi]; // RQ2
            end else begin : g_noseq
                assign seq_level = 1'b0;
            end

            if (gi == 1) begin : g_ind
                // Indicator mode overrides every other role of pin two
                always_comb begin
                    if (current_limit_indicator_enable) begin
                        if (!power_good_latched) begin
                            next_pg_out[gi]  = 1'b0;  // RQ7
                            next_pg_oe_b[gi] = 1'b0;  // RQ7
                        end else if (overcurrent_live_flag) begin
                            next_pg_out[gi]  = 1'b0;  // RQ9
                            next_pg_oe_b[gi] = 1'b0;  // RQ9
                        end else begin
                            next_pg_out[gi]  = 1'b0;  // RQ8
                            next_pg_oe_b[gi] = 1'b1;  // RQ8
                        end
                    end else if (pg_is_special[gi]) begin
                        next_pg_out[gi]  = seq_level; // RQ2
                        next_pg_oe_b[gi] = 1'b0;
                    end else begin
                        next_pg_out[gi]  = gp_drive & cfg_bus.pg_config_b[`HSPIO_PG_DATA_LSB + gi]; // RQ5
                        next_pg_oe_b[gi] = ~gp_drive;
                    end
                end
            end else begin : g_std
                always_comb begin
                    if (pg_is_special[gi] && gi < 2) begin
                        next_pg_out[gi]  = seq_level; // RQ2
                        next_pg_oe_b[gi] = 1'b0;
                    end else begin
                        // Pins three and four are inputs in their special role
                        next_pg_out[gi]  = gp_drive & cfg_bus.pg_config_b[`HSPIO_PG_DATA_LSB + gi]; // RQ5
                        next_pg_oe_b[gi] = ~gp_drive;
                    end
                end
            end

            // ADC pin: direction, data and converter routing
            assign next_adc_out[gi]  = cfg_bus.adc_io_config[`HSPIO_ADC_DIR_LSB + gi] &
                                       cfg_bus.adc_io_config[`HSPIO_ADC_DATA_LSB + gi]; // RQ5
            assign next_adc_oe_b[gi] = ~cfg_bus.adc_io_config[`HSPIO_ADC_DIR_LSB + gi]; // RQ1
            assign next_adc_chan[gi] = cfg_bus.pg_config_b[`HSPIO_ADC_MON_LSB + gi];    // RQ6

            // Comparator capture regardless of configuration
            assign next_input_status[`HSPIO_STATUS_PG_LSB + gi]  = power_good_pin_above_threshold[gi]; // RQ10
            assign next_input_status[`HSPIO_STATUS_ADC_LSB + gi] = adc_io_pin_above_threshold[gi];     // RQ10
        end
    endgenerate

    // Input roles, current-limit settings
    always_comb begin
        next_pg_in_active = pg_is_special[2] & (power_good_pin_in[2] ^ pg_invert[2]); // RQ3
        next_ext_fault    = pg_is_special[3] & (power_good_pin_in[3] ^ pg_invert[3]); // RQ4
        next_sense_mv     = `HSPIO_SENSE_MIN_MV + {1'b0, sense_voltage_step};          // RQ11
        if (next_sense_mv > `HSPIO_SENSE_MAX_MV) begin
            next_sense_mv = `HSPIO_SENSE_MAX_MV;
        end
        // Linear foldback: limit drops by half the output voltage level
        if (load_power_foldback_enable) begin
            next_limit_scale = `HSPIO_LIMIT_FULL - {1'b0, output_voltage_level[7:1]}; // RQ12
        end else begin
            next_limit_scale = `HSPIO_LIMIT_FULL;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_status <= 8'h00;
            pg_out       <= 4'h0;
            pg_oe_b      <= 4'hF;
            adc_out      <= 4'h0;
            adc_oe_b     <= 4'hF;
            adc_chan     <= 4'h0;
            pg_in_active <= 1'b0;
            ext_fault    <= 1'b0;
            sense_mv     <= `HSPIO_SENSE_MIN_MV;
            limit_scale  <= `HSPIO_LIMIT_FULL;
        end else begin
            input_status <= next_input_status; // RQ10
            pg_out       <= next_pg_out;
            pg_oe_b      <= next_pg_oe_b;
            adc_out      <= next_adc_out;
            adc_oe_b     <= next_adc_oe_b;
            adc_chan     <= next_adc_chan;
            pg_in_active <= next_pg_in_active;
            ext_fault    <= next_ext_fault;
            sense_mv     <= next_sense_mv;
            limit_scale  <= next_limit_scale;
        end
    end

    assign cfg_bus.input_status    = input_status; // RQ13
    assign power_good_pin_out      = pg_out;
    assign power_good_pin_oe_b     = pg_oe_b;
    assign adc_io_pin_out          = adc_out;
    assign adc_io_pin_oe_b         = adc_oe_b;
    assign adc_channel_enable      = adc_chan;
    assign power_good_input_active = pg_in_active;
    assign external_fault_active   = ext_fault;
    assign sense_voltage_mv        = sense_mv;
    assign current_limit_scale     = limit_scale;

endmodule
